// >>> design/tcc_pkg.sv
package tcc_pkg;
  localparam int NCH = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_FINE = 8'h08;
  localparam logic [7:0] OFF_DIR = 8'h0C;
  localparam logic [7:0] OFF_ACT = 8'h10;
  localparam logic [7:0] OFF_EDGE = 8'h14;
  localparam logic [7:0] OFF_FLAG = 8'h18;
  localparam logic [7:0] OFF_IRQEN = 8'h1C;
  localparam logic [7:0] OFF_DISC = 8'h20;
  localparam logic [7:0] OFF_CNT = 8'h24;
  localparam logic [7:0] OFF_TC0 = 8'h40;
  localparam logic [2:0] TC_BLOCK = 3'h2;
  // Control one fields
  localparam int CTRL1_RUN = 7;
  localparam int CTRL1_WAIT = 6;
  localparam int CTRL1_FRZ = 5;
  localparam int CTRL1_PREC = 3;
  localparam logic [7:0] CTRL1_MASK = 8'hE8;
  localparam logic [2:0] COARSE_MAX = 3'h7;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  // Compare actions and bus responses
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> design/tcc_top.sv
// Behaviour
// - Eight channels share one 16-bit up-counter driven by a prescaled clock.
// - Coarse prescaler divides by 1 to 128 in powers of two, 3-bit select.
// - Fine prescaler divides by any factor 1 through 256.
// - Fine prescale value 0x18 gives a divide by 25.
// - Precision select chooses fine prescaler when set, coarse when clear.
// - Counter advances only while the run enable bit is set.
// - Control one can stop the timer in wait and freeze modes.
// - Direction bit clear makes a channel an input capture.
// - Active capture edge copies the counter into the channel register.
// - Edge field: 00 off, 01 rising, 10 falling, 11 any edge.
// - Capture event sets the channel event flag.
// - Interrupt requested only while flag and its enable are both set.
// - Writing one clears a flag; software keeps the timer running meanwhile.
// - Direction bit set makes a channel an output compare.
// - Counter equal to compare register applies the pin action.
// - Action field: 00 none, 01 toggle, 10 low, 11 high.
// - Disconnect register detaches compare actions from pins.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Low power modes
  input wire logic wait_mode,
  input wire logic freeze_mode,
  // Channel pins
  input wire logic [NCH-1:0] ch_in,
  output logic [NCH-1:0] ch_out,
  output logic [NCH-1:0] ch_oe,
  // Interrupt
  output logic irq
);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[7:5] == TC_BLOCK) || (a[7:2] <= OFF_CNT[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic [31:0] rd_data;

  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready = ~w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (s_axi_awvalid && !aw_have_q)
    begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_go)
    begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (s_axi_wvalid && !w_have_q)
    begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_go)
    begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] ctrl1_q;
  logic [2:0] coarse_q;
  logic [7:0] fine_q;
  logic [NCH-1:0] dir_q;
  logic [2*NCH-1:0] act_q;
  logic [2*NCH-1:0] edge_q;
  logic [NCH-1:0] ien_q;
  logic [NCH-1:0] disc_q;
  logic [31:0] wmask;

  assign wmask = merge(32'h0000_0000, 32'hFFFF_FFFF, wstrb_q);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl1_q <= RST_BYTE;
      coarse_q <= '0;
      fine_q <= RST_BYTE;
      dir_q <= RST_BYTE;
      act_q <= RST_HALF;
      edge_q <= RST_HALF;
      ien_q <= RST_BYTE;
      disc_q <= RST_BYTE;
    end
    else if (wr_go)
    begin
      if (hit(awaddr_q, OFF_CTRL1))
        ctrl1_q <= ((ctrl1_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]))
                   & CTRL1_MASK;
      if (hit(awaddr_q, OFF_CTRL2))
        coarse_q <= (coarse_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
      if (hit(awaddr_q, OFF_FINE))
        fine_q <= (fine_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
      if (hit(awaddr_q, OFF_DIR))
        dir_q <= (dir_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
      if (hit(awaddr_q, OFF_ACT))
        act_q <= (act_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      if (hit(awaddr_q, OFF_EDGE))
        edge_q <= (edge_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      if (hit(awaddr_q, OFF_IRQEN))
        ien_q <= (ien_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
      if (hit(awaddr_q, OFF_DISC))
        disc_q <= (disc_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter

  logic run;
  logic tick;
  logic [7:0] div_q;
  logic [7:0] limit;
  logic [CNT_W-1:0] cnt_q;

  assign run = ctrl1_q[CTRL1_RUN]
             & ~(ctrl1_q[CTRL1_WAIT] & wait_mode)
             & ~(ctrl1_q[CTRL1_FRZ] & freeze_mode);
  // Fine divides by value plus one, coarse by two to the select
  assign limit = ctrl1_q[CTRL1_PREC] ? fine_q
               : (8'hFF >> (4'h8 - {1'b0, coarse_q}));
  assign tick = run & (div_q >= limit);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      div_q <= RST_BYTE;
    else if (!run || tick)
      div_q <= RST_BYTE;
    else
      div_q <= div_q + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      cnt_q <= RST_HALF;
    else if (tick)
      cnt_q <= cnt_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  logic [NCH-1:0] in_prev_q;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] cmp_ev;
  logic [NCH-1:0] flag_q;
  logic [NCH-1:0] out_q;
  logic [CNT_W-1:0] tc_q [NCH];
  logic tc_wr;
  logic [2:0] tc_idx;

  assign tc_wr = wr_go & (awaddr_q[7:5] == TC_BLOCK);
  assign tc_idx = awaddr_q[4:2];

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      in_prev_q <= RST_BYTE;
    else
      in_prev_q <= ch_in;
  end

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic rise;
    logic fall;
    assign rise = ch_in[i] & ~in_prev_q[i];
    assign fall = ~ch_in[i] & in_prev_q[i];
    assign cap_ev[i] = ~dir_q[i] & ((edge_q[2*i] & rise)
                     | (edge_q[2*i+1] & fall));
    assign cmp_ev[i] = dir_q[i] & tick & (cnt_q == tc_q[i]);

    AST_CAPTURE: assert property (@(posedge mclk) disable iff (!rstn)
      cap_ev[i] |=> tc_q[i] == $past(cnt_q) && flag_q[i])
      else $error("capture did not latch counter or set flag");
    AST_EDGE_OFF: assert property (@(posedge mclk) disable iff (!rstn)
      edge_q[2*i+1 -: 2] == 2'h0 |-> !cap_ev[i])
      else $error("capture with edge detection disabled");
    AST_LOW: assert property (@(posedge mclk) disable iff (!rstn)
      cmp_ev[i] && act_q[2*i+1 -: 2] == ACT_LOW && !disc_q[i]
      |=> !ch_out[i] && flag_q[i])
      else $error("compare drive low failed");
    AST_TOGGLE: assert property (@(posedge mclk) disable iff (!rstn)
      cmp_ev[i] && act_q[2*i+1 -: 2] == ACT_TOGGLE && !disc_q[i]
      |=> ch_out[i] != $past(ch_out[i]))
      else $error("compare toggle failed");
    AST_DISC: assert property (@(posedge mclk) disable iff (!rstn)
      disc_q[i] || !dir_q[i] |-> !ch_oe[i] ##1 $stable(ch_out[i]))
      else $error("disconnected pin still driven");
  end

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (!rstn)
        tc_q[i] <= RST_HALF;
      else if (cap_ev[i])
        tc_q[i] <= cnt_q;
      else if (tc_wr && tc_idx == i[2:0])
        tc_q[i] <= (tc_q[i] & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
    end
  end

  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      flag_q <= RST_BYTE;
    else if (wr_go && hit(awaddr_q, OFF_FLAG))
      flag_q <= (flag_q & ~(wdata_q[7:0] & wmask[7:0]))
              | cap_ev | cmp_ev;
    else
      flag_q <= flag_q | cap_ev | cmp_ev;
  end

  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (!rstn)
        out_q[i] <= 1'b0;
      else if (cmp_ev[i] && !disc_q[i])
      begin
        case (act_q[2*i +: 2])
          ACT_TOGGLE: out_q[i] <= ~out_q[i];
          ACT_LOW: out_q[i] <= 1'b0;
          ACT_HIGH: out_q[i] <= 1'b1;
          default: out_q[i] <= out_q[i];
        endcase
      end
    end
  end

  assign ch_out = out_q;
  assign ch_oe = dir_q & ~disc_q;
  assign irq = |(flag_q & ien_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (s_axi_araddr[7:5] == TC_BLOCK)
      rd_data = {16'h0, tc_q[s_axi_araddr[4:2]]};
    else if (hit(s_axi_araddr, OFF_CTRL1))
      rd_data = {24'h0, ctrl1_q};
    else if (hit(s_axi_araddr, OFF_CTRL2))
      rd_data = {29'h0, coarse_q};
    else if (hit(s_axi_araddr, OFF_FINE))
      rd_data = {24'h0, fine_q};
    else if (hit(s_axi_araddr, OFF_DIR))
      rd_data = {24'h0, dir_q};
    else if (hit(s_axi_araddr, OFF_ACT))
      rd_data = {16'h0, act_q};
    else if (hit(s_axi_araddr, OFF_EDGE))
      rd_data = {16'h0, edge_q};
    else if (hit(s_axi_araddr, OFF_FLAG))
      rd_data = {24'h0, flag_q};
    else if (hit(s_axi_araddr, OFF_IRQEN))
      rd_data = {24'h0, ien_q};
    else if (hit(s_axi_araddr, OFF_DISC))
      rd_data = {24'h0, disc_q};
    else if (hit(s_axi_araddr, OFF_CNT))
      rd_data = {16'h0, cnt_q};
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] gap_q;
  logic steady_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn || tick)
      gap_q <= RST_BYTE;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end

  // Set after one full tick period with unchanged settings
  always_ff @(posedge mclk)
  begin
    if (!rstn || !run || $changed(limit))
      steady_q <= 1'b0;
    else if (tick)
      steady_q <= 1'b1;
  end

  // Clear of flag 0 with no event competing for it
  sequence flag0_clear_s;
    wr_go && hit(awaddr_q, OFF_FLAG) && wstrb_q[0] && wdata_q[0]
    && !cap_ev[0] && !cmp_ev[0];
  endsequence

  AST_FINE25: assert property (@(posedge mclk) disable iff (!rstn)
    tick && steady_q && ctrl1_q[CTRL1_PREC] && fine_q == 8'h18
    |-> gap_q == 8'd24)
    else $error("fine prescale 0x18 did not divide by 25");
  AST_COARSE1: assert property (@(posedge mclk) disable iff (!rstn)
    run && !ctrl1_q[CTRL1_PREC] && coarse_q == 3'h0 |-> tick)
    else $error("coarse divide by one missed a tick");
  AST_STOP: assert property (@(posedge mclk) disable iff (!rstn)
    !ctrl1_q[CTRL1_RUN] |=> $stable(cnt_q))
    else $error("counter moved while disabled");
  AST_FREEZE: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl1_q[CTRL1_FRZ] && freeze_mode |-> !tick)
    else $error("counter ticked in freeze stop");
  AST_WRAP: assert property (@(posedge mclk) disable iff (!rstn)
    tick && cnt_q == 16'hFFFF |=> cnt_q == 16'h0000)
    else $error("counter did not wrap to zero");
  AST_IRQ: assert property (@(posedge mclk) disable iff (!rstn)
    |((cap_ev | cmp_ev) & ien_q) |=> irq)
    else $error("enabled event raised no interrupt");
  AST_W1C: assert property (@(posedge mclk) disable iff (!rstn)
    flag0_clear_s |=> !flag_q[0])
    else $error("write one did not clear flag");

endmodule
`default_nettype wire

// >>> verification/tcc_pins.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_pins
  import tcc_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Levels the bench wants on the external signals
  input wire logic [NCH-1:0] lvl,
  // Timer channel pins
  input wire logic [NCH-1:0] ch_out,
  input wire logic [NCH-1:0] ch_oe,
  output logic [NCH-1:0] ch_in
);
  logic [NCH-1:0] ext_q;

  // External sources change one cycle after the bench asks
  always_ff @(posedge mclk)
  begin
    ext_q <= lvl;
  end

  // A pin that the timer drives reads back the timer's own level
  assign ch_in = (ch_oe & ch_out) | (~ch_oe & ext_q);
endmodule
`default_nettype wire

// >>> verification/timer_capture_compare_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer_capture_compare_unit_tb;
  import tcc_pkg::*;
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, wait_mode, freeze_mode;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, c, f;
  logic [1:0] bresp, rresp, lresp;
  logic [NCH-1:0] lvl, ch_in, ch_out, ch_oe;
  logic [1:0] acts [6] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3};
  logic [5:0] outs = 6'h05;
  int bad_count, n_compared, m, v, s;

  tcc_top uut (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wait_mode(wait_mode), .freeze_mode(freeze_mode),
    .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe), .irq(irq));
  tcc_pins pins (.mclk(mclk), .lvl(lvl), .ch_out(ch_out), .ch_oe(ch_oe),
    .ch_in(ch_in));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is sampled mid-cycle so the handshake edge is known beforehand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    int n;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 50 && !b_t; n++)
    begin
      @(negedge mclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      lresp = bresp;
      @(posedge mclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    // Let one edge pass so the next call never re-raises bready at once
    @(posedge mclk);
    if (!b_t)
    begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic a_t, r_t;
    int n;
    r_t = 1'b0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 50 && !r_t; n++)
    begin
      @(negedge mclk);
      a_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      lresp = rresp;
      @(posedge mclk);
      if (a_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    @(posedge mclk);
    if (!r_t)
    begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    cmp(d, exp);
  endtask

  // Capture on ch0, then on ch1 exactly cyc cycles later
  task automatic win(input int cyc, input logic [15:0] exp);
    logic [31:0] a, b;
    lvl[0] <= ~lvl[0];
    repeat (cyc) @(posedge mclk);
    lvl[1] <= ~lvl[1];
    repeat (4) @(posedge mclk);
    rd(OFF_TC0, a);
    rd(OFF_TC0 + 8'h04, b);
    cmp({16'h0, b[15:0] - a[15:0]}, {16'h0, exp});
    rc(OFF_FLAG, 32'h3);
    cmp({31'h0, irq}, 32'h1);
  endtask

  task automatic cfg(input logic [7:0] c1, input logic [2:0] c2,
    input logic [7:0] fv, input int cyc, input logic [15:0] exp);
    wr(OFF_CTRL1, 32'h80);
    wr(OFF_FLAG, 32'h3);
    cmp({31'h0, irq}, 32'h0);
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_CTRL2, {29'h0, c2});
    wr(OFF_FINE, {24'h0, fv});
    wr(OFF_CTRL1, {24'h0, c1});
    win(cyc, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {wait_mode, freeze_mode} = 2'h0;
    {awaddr, araddr, wdata, lvl} = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rc(OFF_CTRL1, 32'h0);
    rc(OFF_CNT, 32'h0);
    rd(8'hFC, c);
    cmp({30'h0, lresp}, {30'h0, RESP_SLVERR});
    cmp(c, 32'h0);
    wr(8'hFC, 32'hFFFFFFFF);
    cmp({30'h0, lresp}, {30'h0, RESP_SLVERR});
    wr(OFF_CTRL1, 32'h68);
    rc(OFF_CTRL1, 32'h68);
    wr(OFF_EDGE, 32'hF);
    wr(OFF_IRQEN, 32'h1);
    for (s = 0; s < 8; s++) cfg(8'h80, s[2:0], 8'h0, 256, 16'h100 >> s);
    cfg(8'h88, 3'h0, 8'h00, 256, 16'h100);
    cfg(8'h88, 3'h0, 8'hFF, 512, 16'h2);
    cfg(8'h88, 3'h7, 8'h18, 250, 16'hA);
    cfg(8'h80, 3'h7, 8'h18, 256, 16'h2);
    cfg(8'h08, 3'h0, 8'h00, 256, 16'h0);
    wait_mode <= 1'b1;
    cfg(8'hC8, 3'h0, 8'h00, 256, 16'h0);
    cfg(8'h88, 3'h0, 8'h00, 256, 16'h100);
    {wait_mode, freeze_mode} <= 2'h1;
    cfg(8'hA8, 3'h0, 8'h00, 256, 16'h0);
    freeze_mode <= 1'b0;
    cfg(8'h80, 3'h0, 8'h00, 65546, 16'hA);
    // Counter held by the wait stop while the run bit stays set
    wr(OFF_FLAG, 32'h3);
    wait_mode <= 1'b1;
    wr(OFF_CTRL1, 32'hC0);
    rd(OFF_CNT, c);
    for (m = 0; m < 4; m++)
    begin
      wr(OFF_EDGE, {26'h0, m[1:0], 4'hF});
      for (v = 1; v >= 0; v--)
      begin
        lvl[2] <= v[0];
        repeat (4) @(posedge mclk);
        rc(OFF_FLAG, {29'h0, m[1 - v], 2'h0});
        cmp({31'h0, irq}, 32'h0);
        wr(OFF_FLAG, 32'h4);
      end
    end
    rc(OFF_TC0 + 8'h08, c);
    wait_mode <= 1'b0;
    wr(OFF_DIR, 32'h8);
    for (m = 0; m < 6; m++)
    begin
      wr(OFF_DISC, (m == 5) ? 32'hFF : 32'h0);
      wr(OFF_ACT, {24'h0, acts[m], 6'h0});
      rd(OFF_CNT, c);
      wr(OFF_TC0 + 8'h0C, c + 32'h28);
      f = 32'h0;
      for (v = 0; v < 40 && !f[3]; v++) rd(OFF_FLAG, f);
      cmp(f & 32'h8, 32'h8);
      cmp({31'h0, ch_out[3]}, {31'h0, outs[m]});
      cmp({31'h0, ch_oe[3]}, {31'h0, m < 5});
      wr(OFF_FLAG, 32'h8);
    end
    summarize();
  end
endmodule
`default_nettype wire
